/* rtl/adc_seq_params.svh */
// How it works
// - Each cycle runs system zero, input integrate, reference integrate, integrator zero.
// - Integrator zero lasts 150 clocks, inside 100..200, when not overranged.
// - After an overrange the integrator zero phase lasts 6200 clocks.
// - Each phase closes its own fixed set of analog switches, except that the sign picks reference integrate's reference switch.
// - Sign caught at end of input integrate picks the reference switch.
// - A floating run/hold pin reads as 1 through the pad pull-up.
// - Run/hold high converts continuously, one cycle every 40002 clocks.
// - Run/hold low finishes the current cycle, then holds and shows the result.
// - A high pulse over 300 ns starts one cycle, seen only once holding.
// - A pulse-started cycle opens with 10001 auto zero clocks, then busy rises.
// - Strobe pulses low exactly five times per cycle, centred in digit drives.
// - At cycle end MSD drive is high 201 clocks, strobe at clock 101.
// - Lower digits follow 200 clocks each, strobe 100 clocks after rise.
// - Digit drives keep scanning; strobes wait for the next completed cycle.
// - Busy rises at input integrate start and falls after the zero crossing.
// - Overrange without crossing still drops busy when the reference count reaches 20000.
// - Result latch loads on the first clock after busy falls.
// - Overrange flag loads when busy falls, clears at next reference integrate.
// - Low scale flag loads at busy end for 1800 or less, clears at input.
// - Polarity is 1 for positive, valid from reference integrate, held after.
// - On overrange digit drives go low after the last strobe until reference.
// - BCD outputs active high, change with digit edges, zero on overrange.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS    50
`define RUN_PULSE_NS     300
`define RUN_PULSE_CYC    ((`RUN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_CYC        16'h9c42
`define AZ_RUN_CYC       16'h2711
`define INT_CYC          16'h2710
`define IZ_NORMAL_CYC    16'h0096
`define IZ_OVER_CYC      16'h1838
`define REF_LIMIT_BCD    20'h20000
`define LOW_LIMIT_BCD    20'h01800
`define MSD_WIDTH_CYC    8'hc9
`define DIGIT_WIDTH_CYC  8'hc8
`define MSD_STROBE_AT    8'h65
`define DIGIT_STROBE_AT  8'h64
`define STROBES_PER_CYC  3'h5

// ==========================================================
// Register map, byte offsets
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h4
`define ADDR_RESULT      4'h8
`define CTRL_HOLD_BIT    0
`define CTRL_RESET       1'h0

`endif

/* rtl/adc_seq_pkg.sv */
package adc_seq_pkg;
   typedef enum logic [1:0] {
      PH_ZERO  = 2'b00,
      PH_INPUT = 2'b01,
      PH_REF   = 2'b10,
      PH_INTZ  = 2'b11
   } phase_type;
endpackage : adc_seq_pkg

/* rtl/bcd_digit_counter.sv */
`timescale 1ns/1ps
module bcd_digit_counter #(
   parameter logic [3:0] Limit = 4'h9
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       clear,
   input  wire logic       inc,
   output logic [3:0]      value,
   output logic            carry
);
   logic [3:0] value_q;

   assign carry = inc && (value_q == Limit);
   assign value = value_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         value_q <= 4'h0;
      end else if (clear || carry) begin
         value_q <= 4'h0;
      end else if (inc) begin
         value_q <= value_q + 4'h1;
      end
   end
endmodule : bcd_digit_counter

/* rtl/digit_scanner.sv */
`timescale 1ns/1ps
`include "adc_seq_params.svh"
module digit_scanner (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        start,
   input  wire logic        blankRelease,
   input  wire logic        overFlag,
   input  wire logic [19:0] digits,
   output logic [4:0]       digitDrive,
   output logic [3:0]       bcdOut,
   output logic             strobeN
);
   logic [2:0] idx_q, idx_d;
   logic [7:0] cnt_q, cnt_d;
   logic [2:0] left_q, left_d;
   logic       blank_q, blank_d;
   logic [4:0] drive_q;
   logic [3:0] bcd_q;
   logic       strobeN_q;

   function automatic logic [7:0] strobeAt(input logic [2:0] i);
      return (i == 3'h0) ? `MSD_STROBE_AT : `DIGIT_STROBE_AT;
   endfunction : strobeAt

   // ==========================================================
   // Scan sequencing
   always_comb begin
      logic [7:0] last;
      last   = (idx_q == 3'h0) ? 8'(`MSD_WIDTH_CYC - 8'h01) : 8'(`DIGIT_WIDTH_CYC - 8'h01);
      idx_d   = idx_q;
      cnt_d   = cnt_q;
      left_d  = left_q;
      blank_d = blank_q;
      if (start) begin
         idx_d  = 3'h0;
         cnt_d  = 8'h00;
         left_d = `STROBES_PER_CYC;
      end else if (blank_q) begin
         if (blankRelease) begin
            blank_d = 1'b0;
            idx_d   = 3'h0;
            cnt_d   = 8'h00;
         end
      end else begin
         if (left_q != 3'h0 && cnt_q == strobeAt(idx_q)) begin
            left_d = left_q - 3'h1;
            // Blank only after the fifth strobe so the data still transfers
            if (left_q == 3'h1 && overFlag) begin
               blank_d = 1'b1;
            end
         end
         if (cnt_q == last) begin
            cnt_d = 8'h00;
            idx_d = (idx_q == 3'h4) ? 3'h0 : idx_q + 3'h1;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         idx_q   <= 3'h0;
         cnt_q   <= 8'h00;
         left_q  <= 3'h0;
         blank_q <= 1'b0;
      end else begin
         idx_q   <= idx_d;
         cnt_q   <= cnt_d;
         left_q  <= left_d;
         blank_q <= blank_d;
      end
   end

   // ==========================================================
   // Registered outputs, aligned with the scan state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drive_q   <= 5'h00;
         bcd_q     <= 4'h0;
         strobeN_q <= 1'b1;
      end else begin
         drive_q   <= blank_d ? 5'h00 : 5'(5'h10 >> idx_d);
         bcd_q     <= (blank_d || overFlag) ? 4'h0 : digits[4'(4'h4 - 4'(idx_d)) * 4 +: 4];
         strobeN_q <= !(!blank_d && left_d != 3'h0 && cnt_d == strobeAt(idx_d));
      end
   end

   assign digitDrive = drive_q;
   assign bcdOut     = bcd_q;
   assign strobeN    = strobeN_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_strobe_centre: assert property (
      !strobeN_q |-> (drive_q != 5'h00) && (cnt_q == strobeAt(idx_q)))
      else $error("strobe not centred in digit drive");
   chk_blank_drive: assert property (
      blank_q |-> (drive_q == 5'h00) && strobeN_q)
      else $error("digit drive active while blanked");
   chk_strobe_budget: assert property (
      (left_q == 3'h0 && !start) |=> strobeN_q)
      else $error("strobe repeated without a new result");
   chk_bcd_over: assert property (
      $past(overFlag) |-> bcd_q == 4'h0)
      else $error("bcd data not forced to zero on overrange");
endmodule : digit_scanner

/* rtl/dual_slope_sequencer.sv */
`timescale 1ns/1ps
`include "adc_seq_params.svh"
module dual_slope_sequencer #(
   parameter int unsigned FrameCyc  = `FRAME_CYC,
   parameter int unsigned AzRunCyc  = `AZ_RUN_CYC,
   parameter int unsigned IntCyc    = `INT_CYC,
   parameter int unsigned IzOverCyc = `IZ_OVER_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset,
   // Wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Converter pins
   input  wire logic        runHoldControl,
   input  wire logic        comparatorHigh,
   output logic             zeroLoopSwitch,
   output logic             refChargeSwitch,
   output logic             integFeedbackSwitch,
   output logic             inputSwitch,
   output logic             refPosSwitch,
   output logic             refNegSwitch,
   output logic             integZeroSwitch,
   output logic             busy,
   output logic             polarity,
   output logic             overFullScaleFlag,
   output logic             lowScaleFlag,
   output logic             digitDriveMsd,
   output logic             digitDriveFourth,
   output logic             digitDriveThird,
   output logic             digitDriveSecond,
   output logic             digitDriveLsd,
   output logic             bcdWeightEight,
   output logic             bcdWeightFour,
   output logic             bcdWeightTwo,
   output logic             bcdWeightOne,
   output logic             digitStrobeN
);
   localparam logic [2:0] RunPulseCyc = 3'(`RUN_PULSE_CYC);

   adc_seq_pkg::phase_type phase_q, phase_d;
   logic [15:0] phaseCnt_q;
   logic [15:0] frameCnt_q;
   logic        hold_q;
   logic        single_q;
   logic        busy_q;
   logic        polarity_q;
   logic        over_q;
   logic        low_q;
   logic        latchLoad_q;
   logic        scanStart_q;
   logic [2:0]  runCnt_q;
   logic [19:0] result_q;
   logic        ctrlHold_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic [19:0] count;
   logic [4:0]  carry;
   logic        countClear;
   logic        countInc;
   logic        runEff;
   logic        runPulse;
   logic        crossing;
   logic        refOver;
   logic        azDone;
   logic        izDone;
   logic        refEnd;
   logic        inputStart;
   logic [4:0]  drive;
   logic [3:0]  bcd;

   // ==========================================================
   // Run / hold
   // The pad pull-up makes a floating pin read high; software hold gates it
   assign runEff = runHoldControl && !ctrlHold_q;
   // A run request is only looked at once the held cycle is finished
   assign runPulse = hold_q && runEff && (runCnt_q == RunPulseCyc - 3'h1);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         runCnt_q <= 3'h0;
      end else if (hold_q && runEff) begin
         if (runCnt_q != RunPulseCyc - 3'h1) begin
            runCnt_q <= runCnt_q + 3'h1;
         end
      end else begin
         runCnt_q <= 3'h0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hold_q   <= 1'b0;
         single_q <= 1'b1;
      end else begin
         if (phase_q == adc_seq_pkg::PH_INTZ && izDone && !runEff) begin
            hold_q <= 1'b1;
         end else if (runPulse) begin
            hold_q <= 1'b0;
         end
         if (runPulse) begin
            single_q <= 1'b1;
         end else if (inputStart) begin
            single_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Phase sequencing
   assign azDone = single_q ? (phaseCnt_q == 16'(AzRunCyc - 1))
                            : (frameCnt_q >= 16'(FrameCyc - 1));
   assign izDone = phaseCnt_q == (over_q ? 16'(IzOverCyc - 1)
                                         : `IZ_NORMAL_CYC - 16'h0001);
   assign crossing   = (phase_q == adc_seq_pkg::PH_REF) && (comparatorHigh != polarity_q);
   assign refOver    = (phase_q == adc_seq_pkg::PH_REF) && !crossing
                       && (count == `REF_LIMIT_BCD);
   assign refEnd     = (phase_q == adc_seq_pkg::PH_REF) && (phase_d == adc_seq_pkg::PH_INTZ);
   assign inputStart = (phase_q == adc_seq_pkg::PH_ZERO) && (phase_d == adc_seq_pkg::PH_INPUT);
   assign countClear = (phase_q == adc_seq_pkg::PH_INPUT) && (phase_d == adc_seq_pkg::PH_REF);
   assign countInc   = (phase_q == adc_seq_pkg::PH_REF) && (phase_d == adc_seq_pkg::PH_REF);

   always_comb begin
      phase_d = phase_q;
      unique case (phase_q)
         adc_seq_pkg::PH_ZERO: begin
            if (!hold_q && azDone) begin
               phase_d = adc_seq_pkg::PH_INPUT;
            end
         end
         adc_seq_pkg::PH_INPUT: begin
            if (phaseCnt_q == 16'(IntCyc - 1)) begin
               phase_d = adc_seq_pkg::PH_REF;
            end
         end
         adc_seq_pkg::PH_REF: begin
            if (crossing || refOver) begin
               phase_d = adc_seq_pkg::PH_INTZ;
            end
         end
         adc_seq_pkg::PH_INTZ: begin
            if (izDone) begin
               phase_d = adc_seq_pkg::PH_ZERO;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase_q    <= adc_seq_pkg::PH_ZERO;
         phaseCnt_q <= 16'h0000;
      end else begin
         phase_q <= phase_d;
         if (phase_d != phase_q || runPulse) begin
            phaseCnt_q <= 16'h0000;
         end else if (phaseCnt_q != 16'hffff) begin
            phaseCnt_q <= phaseCnt_q + 16'h0001;
         end
      end
   end

   // Period is measured from one input integrate start to the next
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         frameCnt_q <= 16'h0000;
      end else if (inputStart) begin
         frameCnt_q <= 16'h0000;
      end else if (frameCnt_q != 16'hffff) begin
         frameCnt_q <= frameCnt_q + 16'h0001;
      end
   end

   // ==========================================================
   // Reference count, BCD
   for (genvar g = 0; g < 5; g++) begin : g_digit
      bcd_digit_counter #(
         .Limit(4'h9)
      ) u_digit (
         .clk  (clk),
         .reset(reset),
         .clear(countClear),
         .inc  ((g == 0) ? countInc : carry[g > 0 ? g - 1 : 0]),
         .value(count[g * 4 +: 4]),
         .carry(carry[g])
      );
   end

   // ==========================================================
   // Busy, polarity, flags, result latch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_q <= 1'b0;
      end else if (inputStart) begin
         busy_q <= 1'b1;
      end else if (refEnd) begin
         busy_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         polarity_q <= 1'b0;
      end else if (countClear) begin
         polarity_q <= comparatorHigh;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         over_q <= 1'b0;
         low_q  <= 1'b0;
      end else begin
         if (refEnd) begin
            over_q <= refOver;
         end else if (countClear) begin
            over_q <= 1'b0;
         end
         if (refEnd) begin
            low_q <= !refOver && (count <= `LOW_LIMIT_BCD);
         end else if (inputStart) begin
            low_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         latchLoad_q <= 1'b0;
         scanStart_q <= 1'b0;
         result_q    <= 20'h00000;
      end else begin
         latchLoad_q <= refEnd;
         scanStart_q <= latchLoad_q;
         if (latchLoad_q) begin
            result_q <= count;
         end
      end
   end

   // ==========================================================
   // Switch controls
   always_comb begin
      zeroLoopSwitch      = 1'b0;
      refChargeSwitch     = 1'b0;
      integFeedbackSwitch = 1'b0;
      inputSwitch         = 1'b0;
      refPosSwitch        = 1'b0;
      refNegSwitch        = 1'b0;
      integZeroSwitch     = 1'b0;
      unique case (phase_q)
         adc_seq_pkg::PH_ZERO: begin
            zeroLoopSwitch      = 1'b1;
            refChargeSwitch     = 1'b1;
            integFeedbackSwitch = 1'b1;
         end
         adc_seq_pkg::PH_INPUT: begin
            inputSwitch = 1'b1;
         end
         adc_seq_pkg::PH_REF: begin
            integFeedbackSwitch = 1'b1;
            refPosSwitch        = polarity_q;
            refNegSwitch        = !polarity_q;
         end
         adc_seq_pkg::PH_INTZ: begin
            integFeedbackSwitch = 1'b1;
            integZeroSwitch     = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // Display scan
   // Scan starts one clock after busy falls so the latched data is shown
   digit_scanner u_scan (
      .clk         (clk),
      .reset       (reset),
      .start       (scanStart_q),
      .blankRelease(countClear),
      .overFlag    (over_q),
      .digits      (result_q),
      .digitDrive  (drive),
      .bcdOut      (bcd),
      .strobeN     (digitStrobeN)
   );

   assign {digitDriveMsd, digitDriveFourth, digitDriveThird, digitDriveSecond,
           digitDriveLsd} = drive;
   assign {bcdWeightEight, bcdWeightFour, bcdWeightTwo, bcdWeightOne} = bcd;
   assign busy              = busy_q;
   assign polarity          = polarity_q;
   assign overFullScaleFlag = over_q;
   assign lowScaleFlag      = low_q;

   // ==========================================================
   // Wishbone slave, one wait state, writes land on the ack edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= cyc_i && stb_i && !ack_q;
         if (cyc_i && stb_i && !ack_q) begin
            unique case ({adr_i[3:2], 2'b00})
               `ADDR_CTRL:   dat_q <= {31'h00000000, ctrlHold_q};
               `ADDR_STATUS: dat_q <= {24'h000000, hold_q, 1'b0, 2'(phase_q), low_q, over_q,
                                       polarity_q, busy_q};
               `ADDR_RESULT: dat_q <= {12'h000, result_q};
               default:      dat_q <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrlHold_q <= `CTRL_RESET;
      end else if (cyc_i && stb_i && ack_q && we_i && sel_i[0]
                   && {adr_i[3:2], 2'b00} == `ADDR_CTRL) begin
         ctrlHold_q <= dat_i[`CTRL_HOLD_BIT];
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_phase_order: assert property (
      (phase_q != $past(phase_q)) |->
         (phase_q == adc_seq_pkg::phase_type'(2'($past(phase_q) + 2'b01))))
      else $error("measurement phases out of order");
   chk_intz_normal: assert property (
      (phase_q == adc_seq_pkg::PH_INTZ && phase_d == adc_seq_pkg::PH_ZERO && !over_q)
         |-> phaseCnt_q == 16'h0095)
      else $error("integrator zero length wrong without overrange");
   chk_intz_over: assert property (
      (phase_q == adc_seq_pkg::PH_INTZ && phase_d == adc_seq_pkg::PH_ZERO && over_q)
         |-> phaseCnt_q == 16'(IzOverCyc - 1))
      else $error("integrator zero length wrong after overrange");
   chk_switch_input: assert property (
      (phase_q == adc_seq_pkg::PH_INPUT) |-> inputSwitch && !integFeedbackSwitch
         && !refPosSwitch && !refNegSwitch && !zeroLoopSwitch)
      else $error("switch pattern wrong in input integrate");
   chk_ref_sign: assert property (
      $rose(phase_q == adc_seq_pkg::PH_REF) |-> (refPosSwitch == $past(comparatorHigh))
         && (refNegSwitch != refPosSwitch))
      else $error("reference switch does not follow captured sign");
   chk_frame_len: assert property (
      (inputStart && !single_q) |-> frameCnt_q == 16'(FrameCyc - 1))
      else $error("continuous period not kept");
   chk_hold_stay: assert property (
      (hold_q && !runPulse) |=> phase_q == adc_seq_pkg::PH_ZERO && !busy_q)
      else $error("conversion left hold without a run pulse");
   chk_single_az: assert property (
      (inputStart && single_q) |-> phaseCnt_q == 16'(AzRunCyc - 1))
      else $error("single shot auto zero length wrong");
   chk_busy_rise: assert property (
      $rose(busy_q) |-> phase_q == adc_seq_pkg::PH_INPUT && $past(phase_q) == adc_seq_pkg::PH_ZERO)
      else $error("busy rose outside input integrate start");
   chk_busy_fall: assert property (
      $fell(busy_q) |-> phase_q == adc_seq_pkg::PH_INTZ
         && ($past(crossing) || $past(count) == `REF_LIMIT_BCD))
      else $error("busy fell without crossing or overrange");
   chk_latch_load: assert property (
      $fell(busy_q) |=> result_q == $past(count))
      else $error("result latch missed the count");
   chk_over_flag: assert property (
      $rose(over_q) |-> $fell(busy_q))
      else $error("overrange flag set away from busy fall");
   chk_low_clear: assert property (
      $rose(busy_q) |-> !low_q)
      else $error("low scale flag not cleared at input integrate");

   cov_overrange: cover property ($rose(over_q));
   cov_hold_run: cover property (hold_q ##1 runPulse);
   cov_low_scale: cover property ($rose(low_q));
   cov_normal_end: cover property ($fell(busy_q) && !over_q && !low_q);
endmodule : dual_slope_sequencer

/* testbench/strobe_latch.sv */
`timescale 1ns/1ps
// ==========================================
// External latch clocked by clk, loading while the strobe is low
module strobe_latch (
   input  wire logic       clk,
   input  wire logic       strobeN,
   input  wire logic       clear,
   input  wire logic [3:0] bcd,
   output logic [2:0]      count,
   output logic [19:0]     word
);
   // Digits arrive msd first, so shift left
   always_ff @(posedge clk) begin
      if (clear) begin
         count <= 3'h0;
      end else if (!strobeN) begin
         count <= count + 3'h1;
         word  <= {word[15:0], bcd};
      end
   end
endmodule : strobe_latch

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, reset = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, clr = 1'b0;
   logic runHoldControl = 1'b1, comparatorHigh = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic ack_o, zeroLoopSwitch, refChargeSwitch, integFeedbackSwitch, inputSwitch;
   logic refPosSwitch, refNegSwitch, integZeroSwitch, busy, polarity, lowScaleFlag;
   logic overFullScaleFlag, digitDriveMsd, digitDriveFourth, digitDriveThird;
   logic digitDriveSecond, digitDriveLsd, bcdWeightEight, bcdWeightFour;
   logic bcdWeightTwo, bcdWeightOne, digitStrobeN;
   logic [2:0] count;
   logic [19:0] word;
   int fails = 0, checks_done = 0, cycles = 0, n, m, at, t0;
   // Sign seen, expected polarity, positive and negative reference switch
   logic [3:0] rows [2] = '{4'b1110, 4'b0001};
   dual_slope_sequencer #(.FrameCyc(2000), .AzRunCyc(60), .IntCyc(50), .IzOverCyc(160))
   u_dut (.clk, .reset, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .runHoldControl, .comparatorHigh, .zeroLoopSwitch, .refChargeSwitch,
      .integFeedbackSwitch, .inputSwitch, .refPosSwitch, .refNegSwitch, .integZeroSwitch,
      .busy, .polarity, .overFullScaleFlag, .lowScaleFlag, .digitDriveMsd,
      .digitDriveFourth, .digitDriveThird, .digitDriveSecond, .digitDriveLsd,
      .bcdWeightEight, .bcdWeightFour, .bcdWeightTwo, .bcdWeightOne, .digitStrobeN);
   strobe_latch u_latch (.clk, .strobeN(digitStrobeN), .clear(clr), .count, .word,
      .bcd({bcdWeightEight, bcdWeightFour, bcdWeightTwo, bcdWeightOne}));
   always #25 clk = ~clk;
   // ==========================================
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails = fails + 1;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Call only just after a rising edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic print_verdict;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   // ==========================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      check({busy, zeroLoopSwitch, refChargeSwitch, integFeedbackSwitch, digitStrobeN,
         overFullScaleFlag, lowScaleFlag}, 7'h3c);
      reset <= 1'b0;
      @(posedge clk);
      wb(1'b0, 4'hc, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, 4'h0, 32'h1);
      wb(1'b0, 4'h0, 32'h0);
      check(rd, 32'h1);
      wb(1'b1, 4'h0, 32'h0);
      foreach (rows[i]) begin
         comparatorHigh <= rows[i][3];
         do @(posedge clk); while (inputSwitch !== 1'b1);
         if (i == 1) check(cycles - t0, 2000);
         t0 = cycles;
         repeat (2) @(posedge clk);
         check({busy, zeroLoopSwitch, integFeedbackSwitch}, 3'h4);
         do @(posedge clk); while (integFeedbackSwitch !== 1'b1);
         @(posedge clk);
         check({polarity, refPosSwitch, refNegSwitch, inputSwitch}, {rows[i][2:0], 1'b0});
         repeat (3) @(posedge clk);
         comparatorHigh <= ~rows[i][3];
         do @(posedge clk); while (busy !== 1'b0);
         clr <= 1'b1;
         n = 0;
         // Scan start lands a clock later; skip the free-running drive sample
         m = integZeroSwitch;
         @(posedge clk);
         m += integZeroSwitch;
         do begin
            @(posedge clk);
            clr <= 1'b0;
            n += digitDriveMsd;
            m += integZeroSwitch;
            if (!digitStrobeN) at = n;
         end while (digitDriveMsd === 1'b1 || n == 0);
         check(n, 201);
         check(at, 102);
         check(m, 150);
         check(zeroLoopSwitch, 1'b1);
         repeat (1500) @(posedge clk);
         check({count, word, lowScaleFlag, overFullScaleFlag}, 25'h1400016);
      end
      // Cycle waiting in auto zero still runs; no crossing, so it overranges
      runHoldControl <= 1'b0;
      do @(posedge clk); while (busy !== 1'b1);
      do @(posedge clk); while (busy !== 1'b0);
      clr <= 1'b1;
      check({overFullScaleFlag, lowScaleFlag, integZeroSwitch}, 3'h5);
      @(posedge clk);
      clr <= 1'b0;
      repeat (1500) @(posedge clk);
      check({count, word}, 23'h500000);
      check({digitDriveMsd, digitDriveFourth, digitDriveThird}, 3'h0);
      check({digitDriveSecond, digitDriveLsd, busy, zeroLoopSwitch}, 4'h1);
      runHoldControl <= 1'b1;
      repeat (6) @(posedge clk);
      runHoldControl <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b1);
      check(n, 61);
      print_verdict();
   end
endmodule : testbench
